// ===== logic/dce_pkg.sv
package dce_pkg;
  // command codes on the cmd port
  localparam logic [1:0] CMD_CONVERT = 2'h0;
  localparam logic [1:0] CMD_EDIT = 2'h1;
  // instruction field positions
  localparam int EXT_BIT = 12;
  localparam int REG_LSB = 13;
  // conversion field shape
  localparam logic [3:0] DEC_DIGITS = 4'hB;
  localparam logic [2:0] DEC_BYTES = 3'h6;
  localparam logic [3:0] SIGN_PLUS = 4'hC;
  localparam logic [3:0] SIGN_MINUS = 4'hD;
  localparam logic [2:0] REG_LAST = 3'h7;
  // edit function codes
  localparam logic [3:0] FN_STOP = 4'h0;
  localparam logic [3:0] FN_STOP_ALT = 4'h1;
  localparam logic [3:0] FN_MARK = 4'h2;
  localparam logic [3:0] FN_MARK_ALT = 4'h3;
  localparam logic [3:0] FN_INS = 4'h4;
  localparam logic [3:0] FN_INS_PAD = 4'h5;
  localparam logic [3:0] FN_LOAD_PAD = 4'h6;
  localparam logic [3:0] FN_SIGN = 4'h7;
  localparam logic [3:0] FN_COPY = 4'h8;
  localparam logic [3:0] FN_COPY_PAD = 4'h9;
  localparam logic [3:0] FN_COPY_C = 4'hC;
  localparam logic [3:0] FN_COPY_PAD_D = 4'hD;
  // character constants
  localparam logic [7:0] CHR_SPACE = 8'h40;
  localparam logic [7:0] CHR_PLUS = 8'h4E;
  localparam logic [3:0] ZONE_DIGIT = 4'hF;
  // condition bits (bit 0 is the lsb of the 16-bit register)
  localparam int CC_GT = 14;
  localparam int CC_LT = 13;
  localparam int CC_EQ = 12;
  localparam int CC_INV = 11;
  localparam logic [15:0] ADDR_ONE = 16'h0001;
  localparam logic [15:0] ADDR_ZERO = 16'h0000;
endpackage

// ===== logic/decimal_convert_edit_unit.sv
// The implementer's own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
module decimal_convert_edit_unit
  import dce_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // command
  input wire logic start,
  input wire logic [1:0] cmd,
  input wire logic [15:0] instr,
  input wire logic [15:0] addr1,
  input wire logic [15:0] addr2,
  input wire logic [7:0] src_len,
  input wire logic [7:0] res_len,
  input wire logic [15:0] reg1_in,
  input wire logic [15:0] cond_in,
  output logic busy_ff,
  output logic done_ff,
  // general register read port
  output logic [2:0] reg_sel_ff,
  input wire logic [15:0] reg_data,
  // general register 1 and condition write back
  output logic reg1_we_ff,
  output logic [15:0] reg1_out_ff,
  output logic cond_we_ff,
  output logic [15:0] cond_out_ff,
  // storage byte port
  output logic mem_req_ff,
  output logic mem_we_ff,
  output logic [15:0] mem_addr_ff,
  output logic [7:0] mem_wdata_ff,
  input wire logic mem_ack,
  input wire logic [7:0] mem_rdata
);
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000, ST_RD_HI = 4'b0001, ST_RD_LO = 4'b0010, ST_CONV = 4'b0011,
    ST_WR_PK = 4'b0100, ST_UNPK = 4'b0101, ST_OP = 4'b0110, ST_ARG = 4'b0111,
    ST_EXEC = 4'b1000, ST_SRC = 4'b1001, ST_PUT = 4'b1010, ST_WAIT = 4'b1011,
    ST_FIN = 4'b1100
  } state_e;
  typedef struct packed {
    state_e st;
    state_e ret;
    logic busy, done, numeric, sig, neg, zero, pend, seeded;
    logic [2:0] rsel;
    logic [31:0] bin;
    logic [47:0] bcd;
    logic [5:0] cnt;
    logic [15:0] mptr, sptr, rptr, float_addr;
    logic [7:0] pad, op, arg1, arg2, ch;
    logic [3:0] rep, didx, wcnt;
    logic [1:0] sg; // 2'h2 greater, 2'h1 less, 2'h0 equal
    logic rwe, cwe, mreq, mwe;
    logic [15:0] r1, cc, maddr;
    logic [7:0] mwd;
  } unit_s;
  unit_s cur_ff, nxt_s;
  logic [3:0] dig_q;
  logic dwe;

  // add-3 correction of one binary to packed decimal step; the caller does the shift
  function automatic logic [47:0] dabble(input logic [47:0] b);
    logic [47:0] r;
    r = b;
    for (int i = 0; i < 12; i++) begin
      if (r[i*4 +: 4] > 4'h4) begin
        r[i*4 +: 4] = r[i*4 +: 4] + 4'h3;
      end
    end
    return r;
  endfunction

  // start a single byte storage access and park in the wait state
  function automatic unit_s access(input unit_s s, input logic we, input logic [15:0] a,
                                   input logic [7:0] d, input state_e back);
    unit_s r;
    r = s;
    r.mreq = 1'b1;
    r.mwe = we;
    r.maddr = a;
    r.mwd = d;
    r.ret = back;
    r.st = ST_WAIT;
    return r;
  endfunction

  digit_store u_digits (
    .mclk(mclk),
    .wr_en(dwe),
    .wr_addr(cur_ff.wcnt),
    .wr_data(cur_ff.ch[3:0]),
    .rd_addr(cur_ff.didx),
    .rd_data_ff(dig_q)
  );

  assign dwe = (cur_ff.st == ST_UNPK) && cur_ff.pend;

  always_comb begin
    logic [3:0] fn;
    logic [7:0] schar;
    logic [31:0] mag;
    logic [47:0] adj;
    fn = cur_ff.op[3:0];
    adj = '0;
    schar = {ZONE_DIGIT, dig_q};
    mag = '0;
    nxt_s = cur_ff;
    nxt_s.done = 1'b0;
    nxt_s.rwe = 1'b0;
    nxt_s.cwe = 1'b0;
    case (cur_ff.st)
      ST_IDLE: begin
        if (start) begin
          nxt_s.busy = 1'b1;
          // conversions must not write register 1 back at the end
          nxt_s.numeric = 1'b0;
          nxt_s.mptr = ADDR_ZERO;
          if (cmd == CMD_CONVERT && instr[EXT_BIT]) begin
            nxt_s.rsel = instr[REG_LSB +: 3];
            nxt_s.st = ST_RD_HI;
          end else if (cmd == CMD_EDIT) begin
            nxt_s.numeric = (res_len != 8'h00);
            nxt_s.sig = 1'b0;
            nxt_s.pad = CHR_SPACE;
            nxt_s.float_addr = ADDR_ZERO;
            nxt_s.mptr = reg1_in;
            nxt_s.sptr = addr1;
            nxt_s.rptr = addr2;
            nxt_s.wcnt = '0;
            nxt_s.didx = '0;
            nxt_s.zero = 1'b1;
            nxt_s.pend = 1'b0;
            nxt_s.cnt = '0;
            nxt_s.st = (res_len != 8'h00) ? ST_UNPK : ST_OP;
          end else begin
            // single-word conversion lives elsewhere; answer at once
            nxt_s.st = ST_FIN;
          end
        end
      end
      ST_RD_HI: begin
        nxt_s.bin[31:16] = reg_data;
        nxt_s.rsel = cur_ff.rsel + 3'h1; // 7 wraps to 0
        nxt_s.st = ST_RD_LO;
      end
      ST_RD_LO: begin
        nxt_s.neg = cur_ff.bin[31];
        mag = cur_ff.bin[31] ? (~{cur_ff.bin[31:16], reg_data} + 32'h1) : {cur_ff.bin[31:16], reg_data};
        nxt_s.bin = mag;
        nxt_s.bcd = '0;
        nxt_s.cnt = '0;
        nxt_s.st = ST_CONV;
      end
      ST_CONV: begin
        // 32 serial steps trade speed for a single adder rank
        adj = dabble(cur_ff.bcd);
        nxt_s.bcd = {adj[46:0], cur_ff.bin[31]};
        nxt_s.bin = {cur_ff.bin[30:0], 1'b0};
        nxt_s.cnt = cur_ff.cnt + 6'h1;
        if (cur_ff.cnt == 6'h1F) begin
          nxt_s.st = ST_WR_PK;
          nxt_s.cnt = '0;
          nxt_s.maddr = addr1;
        end
      end
      ST_WR_PK: begin
        if (cur_ff.cnt[2:0] == DEC_BYTES) begin
          nxt_s.st = ST_FIN;
        end else begin
          nxt_s.bcd = {cur_ff.bcd[39:0], 8'h00};
          nxt_s.cnt = cur_ff.cnt + 6'h1;
          // last byte gets the sign nibble after digit eleven
          nxt_s = access(nxt_s, 1'b1, addr1 + {10'h0, cur_ff.cnt},
                         (cur_ff.cnt[2:0] == DEC_BYTES - 3'h1) ?
                         {cur_ff.bcd[7:4], cur_ff.neg ? SIGN_MINUS : SIGN_PLUS} :
                         {cur_ff.bcd[43:40], cur_ff.bcd[39:36]}, ST_WR_PK);
          if (cur_ff.cnt[2:0] == DEC_BYTES - 3'h1) begin
            nxt_s.mwd = {cur_ff.bcd[43:40], cur_ff.neg ? SIGN_MINUS : SIGN_PLUS};
          end
        end
      end
      ST_UNPK: begin
        // fetch one packed byte, store high then low nibble as digits
        nxt_s.pend = 1'b0;
        if (cur_ff.pend) begin
          nxt_s.wcnt = cur_ff.wcnt + 4'h1;
          // the sign nibble sits past the last digit and must not clear zero
          nxt_s.zero = cur_ff.zero & ((cur_ff.ch[3:0] == 4'h0) || ({4'h0, cur_ff.wcnt} >= src_len));
          nxt_s.ch = {4'h0, cur_ff.arg1[3:0]};
          nxt_s.pend = cur_ff.seeded;
          nxt_s.seeded = 1'b0;
        end else if ({2'h0, cur_ff.wcnt} >= src_len[5:0] || cur_ff.wcnt == 4'hF) begin
          nxt_s.sg = cur_ff.zero ? 2'h0 : (cur_ff.neg ? 2'h1 : 2'h2);
          nxt_s.cc = cond_in;
          nxt_s.cc[CC_GT] = !cur_ff.zero && !cur_ff.neg;
          nxt_s.cc[CC_LT] = !cur_ff.zero && cur_ff.neg;
          nxt_s.cc[CC_EQ] = cur_ff.zero;
          nxt_s.cc[CC_INV] = 1'b0;
          nxt_s.cwe = 1'b1;
          nxt_s.st = ST_OP;
        end else begin
          nxt_s = access(nxt_s, 1'b0, cur_ff.sptr, 8'h00, ST_UNPK);
          nxt_s.sptr = cur_ff.sptr + ADDR_ONE;
          nxt_s.cnt = 6'h3F; // marks an unpack fetch
        end
      end
      ST_OP: begin
        nxt_s = access(nxt_s, 1'b0, cur_ff.mptr, 8'h00, ST_ARG);
        nxt_s.mptr = cur_ff.mptr + ADDR_ONE;
        nxt_s.cnt = 6'h00;
      end
      ST_ARG: begin
        nxt_s.rep = cur_ff.op[7:4];
        if (fn == FN_INS || fn == FN_INS_PAD || fn == FN_LOAD_PAD ||
            (fn == FN_SIGN && cur_ff.sg == 2'h1 && cur_ff.cnt == 6'h00)) begin
          nxt_s = access(nxt_s, 1'b0, cur_ff.mptr, 8'h00, ST_ARG);
          nxt_s.mptr = cur_ff.mptr + ADDR_ONE;
          nxt_s.cnt = cur_ff.cnt + 6'h1;
          if (cur_ff.cnt != 6'h00 || !(fn == FN_SIGN && cur_ff.op[7:4] == 4'h2)) begin
            nxt_s.st = (cur_ff.cnt == 6'h00) ? ST_WAIT : ST_EXEC;
          end
          if (cur_ff.cnt != 6'h00) begin
            nxt_s.mreq = 1'b0;
            nxt_s.mptr = cur_ff.mptr;
            nxt_s.st = ST_EXEC;
          end
        end else begin
          nxt_s.st = ST_EXEC;
        end
      end
      ST_EXEC: begin
        nxt_s.st = ST_OP;
        if (fn == FN_STOP || fn == FN_STOP_ALT) begin
          nxt_s.st = ST_FIN;
        end else if (fn == FN_MARK || fn == FN_MARK_ALT) begin
          // controls touch neither source nor result
          if (!cur_ff.sig && (cur_ff.op[4] || (cur_ff.numeric && cur_ff.sg != 2'h0))) begin
            nxt_s.sig = 1'b1;
            nxt_s.float_addr = cur_ff.rptr - ADDR_ONE;
          end
        end else if (fn == FN_LOAD_PAD) begin
          nxt_s.pad = cur_ff.arg1;
        end else if (fn == FN_INS || fn == FN_INS_PAD) begin
          nxt_s.ch = (fn == FN_INS_PAD && !cur_ff.sig) ? cur_ff.pad : cur_ff.arg1;
          nxt_s.st = ST_PUT;
        end else if (fn == FN_SIGN) begin
          nxt_s.ch = (cur_ff.sg == 2'h1) ? cur_ff.arg1 : (cur_ff.op[7:4] == 4'h0 ? CHR_PLUS : CHR_SPACE);
          nxt_s.rep = (cur_ff.op[7:4] == 4'h2) ? 4'h1 : 4'h0;
          nxt_s.st = ST_PUT;
        end else if (fn[3]) begin
          nxt_s.st = ST_SRC;
        end
      end
      ST_SRC: begin
        if (cur_ff.numeric) begin
          // digit from the unpacked store, read data is registered
          if (cur_ff.cnt == 6'h00) begin
            nxt_s.cnt = 6'h01;
          end else begin
            nxt_s.cnt = 6'h00;
            nxt_s.didx = cur_ff.didx + 4'h1;
            if ((fn == FN_COPY || fn == FN_COPY_C || fn == FN_COPY_PAD || fn == FN_COPY_PAD_D) &&
                (cur_ff.sig || dig_q != 4'h0 || fn == FN_COPY || fn == FN_COPY_C)) begin
              if (!cur_ff.sig) begin
                nxt_s.float_addr = cur_ff.rptr - ADDR_ONE;
              end
              nxt_s.sig = 1'b1;
              nxt_s.ch = schar;
            end else if (cur_ff.sig) begin
              nxt_s.ch = schar;
            end else begin
              nxt_s.ch = cur_ff.pad;
            end
            nxt_s.st = ST_PUT;
          end
        end else begin
          nxt_s = access(nxt_s, 1'b0, cur_ff.sptr, 8'h00, ST_PUT);
          nxt_s.sptr = cur_ff.sptr + ADDR_ONE;
          nxt_s.cnt = 6'h3E; // marks a source character fetch
        end
      end
      ST_PUT: begin
        nxt_s = access(nxt_s, 1'b1, cur_ff.rptr, cur_ff.ch, ST_PUT);
        nxt_s.rptr = cur_ff.rptr + ADDR_ONE;
        nxt_s.cnt = 6'h3D;
        if (fn == FN_SIGN && cur_ff.rep != 4'h0 && cur_ff.sg == 2'h1) begin
          nxt_s.ch = cur_ff.arg2;
        end
      end
      ST_WAIT: begin
        nxt_s.mreq = 1'b0;
        if (mem_ack) begin
          nxt_s.st = cur_ff.ret;
          if (cur_ff.ret == ST_UNPK) begin
            nxt_s.ch = {4'h0, mem_rdata[7:4]};
            nxt_s.arg1 = mem_rdata;
            nxt_s.pend = 1'b1;
            nxt_s.seeded = 1'b1;
            nxt_s.neg = (mem_rdata[3:0] == SIGN_MINUS) || (mem_rdata[3:0] == 4'hB);
          end else if (cur_ff.ret == ST_ARG && cur_ff.cnt == 6'h00) begin
            nxt_s.op = mem_rdata;
          end else if (cur_ff.ret == ST_ARG) begin
            if (cur_ff.cnt == 6'h01) begin
              nxt_s.arg1 = mem_rdata;
            end else begin
              nxt_s.arg2 = mem_rdata;
            end
          end else if (cur_ff.ret == ST_PUT && cur_ff.cnt == 6'h3E) begin
            nxt_s.ch = mem_rdata;
          end else if (cur_ff.ret == ST_PUT && cur_ff.cnt == 6'h3D) begin
            // while rep is nonzero write again (copies fetch their next source first), else fetch the next mask op
            nxt_s.cnt = 6'h00;
            if (cur_ff.rep != 4'h0) begin
              nxt_s.rep = cur_ff.rep - 4'h1;
              nxt_s.st = (fn[3] && fn != FN_SIGN) ? ST_SRC : ST_PUT;
            end else begin
              nxt_s.st = ST_OP;
            end
          end
        end
      end
      ST_FIN: begin
        nxt_s.busy = 1'b0;
        nxt_s.done = 1'b1;
        // only an edit leaves a nonzero mask pointer or the numeric flag behind
        nxt_s.rwe = cur_ff.numeric || cur_ff.mptr != ADDR_ZERO;
        nxt_s.r1 = cur_ff.numeric ? (cur_ff.sig ? cur_ff.float_addr : ADDR_ZERO) : ADDR_ZERO;
        nxt_s.cwe = 1'b0;
        nxt_s.st = ST_IDLE;
      end
      default: begin
        nxt_s.st = ST_IDLE;
      end
    endcase
    if (sys_rst) begin
      nxt_s = '0;
      nxt_s.pad = CHR_SPACE;
    end
  end

  // all state but the digit store in one register
  always_ff @(posedge mclk) begin
    cur_ff <= nxt_s;
  end

  // outputs straight from the state register
  always_comb begin
    busy_ff = cur_ff.busy;
    done_ff = cur_ff.done;
    reg_sel_ff = cur_ff.rsel;
    reg1_we_ff = cur_ff.rwe;
    reg1_out_ff = cur_ff.r1;
    cond_we_ff = cur_ff.cwe;
    cond_out_ff = cur_ff.cc;
    mem_req_ff = cur_ff.mreq;
    mem_we_ff = cur_ff.mwe;
    mem_addr_ff = cur_ff.maddr;
    mem_wdata_ff = cur_ff.mwd;
  end
endmodule

// ===== logic/digit_store.sv
`timescale 1ns/1ps
// small digit memory for the unpacked source, registered read data
module digit_store (
  // clock
  input wire logic mclk,
  // write port
  input wire logic wr_en,
  input wire logic [3:0] wr_addr,
  input wire logic [3:0] wr_data,
  // read port
  input wire logic [3:0] rd_addr,
  output logic [3:0] rd_data_ff
);
  logic [3:0] mem [16];
  // no reset: contents are always written before they are read
  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data_ff <= mem[rd_addr];
  end
endmodule

// ===== testbench/dce_chk.sv
`timescale 1ns/1ps
module dce_chk
  import dce_pkg::*;
(
  // clock, reset, command
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic start,
  input wire logic [1:0] cmd,
  input wire logic [15:0] instr,
  input wire logic [15:0] addr1,
  input wire logic [7:0] res_len,
  input wire logic [15:0] reg1_in,
  input wire logic busy_ff,
  input wire logic done_ff,
  // register and storage side
  input wire logic [2:0] reg_sel_ff,
  input wire logic reg1_we_ff,
  input wire logic [15:0] reg1_out_ff,
  input wire logic cond_we_ff,
  input wire logic [15:0] cond_out_ff,
  input wire logic mem_req_ff,
  input wire logic mem_we_ff,
  input wire logic [15:0] mem_addr_ff,
  input wire logic [7:0] mem_wdata_ff,
  input wire logic mem_ack
);
  logic [2:0] sel_ff;
  logic conv_ff;
  logic alpha_ff;
  logic pend_ff;
  logic [15:0] base_ff;
  logic [15:0] mask_ff;
  wire taken = start && !busy_ff;
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // remember the accepted command and whether a storage access is open
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      {sel_ff, conv_ff, alpha_ff, pend_ff, base_ff, mask_ff} <= '0;
    end else begin
      pend_ff <= mem_req_ff || (pend_ff && !mem_ack);
      if (taken) begin
        sel_ff <= instr[15:13];
        conv_ff <= cmd == CMD_CONVERT;
        alpha_ff <= cmd == CMD_EDIT && res_len == 8'h00;
        base_ff <= addr1;
        mask_ff <= reg1_in;
      end
    end
  end
  a_pair_select: assert property (
    taken && cmd == CMD_CONVERT && instr[EXT_BIT] |=> reg_sel_ff == sel_ff ##1 reg_sel_ff == sel_ff + 3'h1)
    else $error("register pair select wrong");
  a_short_idle: assert property (
    taken && cmd == CMD_CONVERT && !instr[EXT_BIT] |=> !mem_req_ff [*8]) else $error("short form touched storage");
  a_convert_span: assert property (
    mem_req_ff && conv_ff |-> mem_we_ff && (mem_addr_ff - base_ff) < 16'h0006) else $error("packed write outside field");
  a_sign_nibble: assert property (
    mem_req_ff && conv_ff && mem_addr_ff == base_ff + 16'h0005
    |-> mem_wdata_ff[3:0] == SIGN_PLUS || mem_wdata_ff[3:0] == SIGN_MINUS) else $error("last byte lacks sign");
  a_hold_access: assert property (
    pend_ff && !mem_ack |-> $stable(mem_addr_ff) && $stable(mem_we_ff) && $stable(mem_wdata_ff))
    else $error("access changed before ack");
  a_one_open: assert property (mem_req_ff |-> !pend_ff) else $error("second access while one open");
  a_mask_kept: assert property (
    mem_req_ff && mem_we_ff && !conv_ff |-> mem_addr_ff != mask_ff) else $error("mask written");
  a_alpha_cond: assert property (alpha_ff |-> !cond_we_ff) else $error("alpha edit wrote conditions");
  a_alpha_reg1: assert property (
    alpha_ff && reg1_we_ff |-> reg1_out_ff == ADDR_ZERO) else $error("alpha edit left register 1 nonzero");
  a_cond_bits: assert property (
    cond_we_ff |-> !cond_out_ff[CC_INV] && $onehot({cond_out_ff[CC_GT], cond_out_ff[CC_LT], cond_out_ff[CC_EQ]}))
    else $error("condition bits malformed");
endmodule
bind decimal_convert_edit_unit dce_chk u_chk (.mclk(mclk), .sys_rst(sys_rst), .start(start), .cmd(cmd),
  .instr(instr), .addr1(addr1), .res_len(res_len), .reg1_in(reg1_in), .busy_ff(busy_ff), .done_ff(done_ff),
  .reg_sel_ff(reg_sel_ff), .reg1_we_ff(reg1_we_ff), .reg1_out_ff(reg1_out_ff), .cond_we_ff(cond_we_ff),
  .cond_out_ff(cond_out_ff), .mem_req_ff(mem_req_ff), .mem_we_ff(mem_we_ff), .mem_addr_ff(mem_addr_ff),
  .mem_wdata_ff(mem_wdata_ff), .mem_ack(mem_ack));

// ===== testbench/store_model.sv
`timescale 1ns/1ps
module store_model (
  // clock, reset, pace
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic slow,
  // register read port
  input wire logic [2:0] reg_sel,
  output logic [15:0] reg_data,
  // storage byte port
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  output logic mem_ack,
  output logic [7:0] mem_rdata
);
  logic [7:0] mem [0:255];
  logic [15:0] gr [0:7];
  logic pend;
  logic [1:0] wait_n;
  initial begin
    mem_ack = 1'b0;
    mem_rdata = 8'h00;
  end
  assign reg_data = gr[reg_sel];
  // one access served at a time; read data scrambles outside the ack cycle so stale bytes never pass
  always @(posedge mclk) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (sys_rst) begin
      pend <= 1'b0;
    end else if (mem_req) begin
      pend <= 1'b1;
      wait_n <= slow ? 2'h3 : 2'h0;
    end else if (pend && wait_n != 2'h0) begin
      wait_n <= wait_n - 2'h1;
    end else if (pend) begin
      pend <= 1'b0;
      mem_ack <= 1'b1;
      mem_rdata <= mem[mem_addr[7:0]];
      if (mem_we)
        mem[mem_addr[7:0]] <= mem_wdata;
    end
  end
endmodule

// ===== testbench/tb_decimal_convert_edit_unit.sv
`timescale 1ns/1ps
module tb_decimal_convert_edit_unit
  import dce_pkg::*;
;
  logic mclk, sys_rst, start, slow, busy_ff, done_ff, reg1_we_ff, cond_we_ff, mem_req_ff, mem_we_ff, mem_ack;
  logic [1:0] cmd;
  logic [2:0] reg_sel_ff;
  logic [7:0] src_len, res_len, mem_wdata_ff, mem_rdata;
  logic [15:0] instr, addr1, addr2, reg1_in, cond_in, reg_data, reg1_out_ff, cond_out_ff, mem_addr_ff, r1_seen, cc_seen;
  logic got_r1, got_cc;
  int checks = 0;
  int fail_count = 0;
  decimal_convert_edit_unit dut (.mclk(mclk), .sys_rst(sys_rst), .start(start), .cmd(cmd), .instr(instr),
    .addr1(addr1), .addr2(addr2), .src_len(src_len), .res_len(res_len), .reg1_in(reg1_in), .cond_in(cond_in),
    .busy_ff(busy_ff), .done_ff(done_ff), .reg_sel_ff(reg_sel_ff), .reg_data(reg_data), .reg1_we_ff(reg1_we_ff),
    .reg1_out_ff(reg1_out_ff), .cond_we_ff(cond_we_ff), .cond_out_ff(cond_out_ff), .mem_req_ff(mem_req_ff),
    .mem_we_ff(mem_we_ff), .mem_addr_ff(mem_addr_ff), .mem_wdata_ff(mem_wdata_ff), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata));
  store_model pm (.mclk(mclk), .sys_rst(sys_rst), .slow(slow), .reg_sel(reg_sel_ff), .reg_data(reg_data),
    .mem_req(mem_req_ff), .mem_we(mem_we_ff), .mem_addr(mem_addr_ff), .mem_wdata(mem_wdata_ff),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // catch write-backs of the running command; cleared at each start
  always @(posedge mclk) begin
    if (start) begin
      got_r1 <= 1'b0;
      got_cc <= 1'b0;
    end
    if (reg1_we_ff) begin
      got_r1 <= 1'b1;
      r1_seen <= reg1_out_ff;
    end
    if (cond_we_ff) begin
      got_cc <= 1'b1;
      cc_seen <= cond_out_ff;
    end
  end
  task automatic summarize;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check16(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  // expected packed field: eleven digits then sign nibble
  function automatic logic [47:0] to_packed(input logic [31:0] v);
    logic [31:0] m;
    logic [47:0] r;
    m = v[31] ? -v : v;
    r = {44'h0, v[31] ? SIGN_MINUS : SIGN_PLUS};
    for (int i = 1; i < 12; i++) begin
      r[i*4 +: 4] = 4'(m % 10);
      m = m / 10;
    end
    return r;
  endfunction
  // one command from start pulse to done, bounded wait
  task automatic run(input logic [1:0] c, input logic [15:0] ins, a1, a2, r1, input logic [7:0] sl, rl);
    int n;
    @(posedge mclk);
    cmd <= c;
    instr <= ins;
    addr1 <= a1;
    addr2 <= a2;
    reg1_in <= r1;
    src_len <= sl;
    res_len <= rl;
    start <= 1'b1;
    @(posedge mclk);
    start <= 1'b0;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (done_ff !== 1'b1 && n < 3000);
    // the register 1 write-back is captured one edge after done
    @(negedge mclk);
    if (n >= 3000) begin
      $display("unexpected done expected 1 seen %b", done_ff);
      fail_count++;
      summarize();
    end
  endtask
  // both register selects, one wrapping 7 to 0, prompt and slow storage
  task automatic t_convert;
    logic [47:0] e;
    for (int k = 0; k < 2; k++) begin
      pm.gr[k ? 7 : 3] = k ? 16'hFFFF : 16'h7FFF;
      pm.gr[k ? 0 : 4] = k ? 16'hFFFE : 16'hFFFF;
      e = to_packed(k ? 32'hFFFFFFFE : 32'h7FFFFFFF);
      slow <= k[0];
      run(CMD_CONVERT, {k ? 3'h7 : 3'h3, 1'b1, 12'h000}, 16'h0010, 16'h0000, 16'h0000, 8'h00, 8'h00);
      for (int b = 0; b < 6; b++)
        check8("packed byte", e[47-8*b -: 8], pm.mem[8'h10+b]);
    end
  endtask
  // bit 12 low: the short form is absent, storage stays as it was
  task automatic t_short;
    for (int b = 0; b < 6; b++)
      pm.mem[8'h10+b] = 8'hAA;
    run(CMD_CONVERT, 16'h6000, 16'h0010, 16'h0000, 16'h0000, 8'h00, 8'h00);
    for (int b = 0; b < 6; b++)
      check8("untouched byte", 8'hAA, pm.mem[8'h10+b]);
  endtask
  // edit with source at 40, mask at 60, result at 80; cc is {gt, lt, eq, invalid}
  task automatic t_edit(input logic [15:0] src, input logic [31:0] mask, input logic [7:0] rl,
                        input logic [23:0] exp, input logic [3:0] cc, input logic [15:0] r1e);
    {pm.mem[8'h40], pm.mem[8'h41]} = src;
    {pm.mem[8'h60], pm.mem[8'h61], pm.mem[8'h62], pm.mem[8'h63]} = mask;
    {pm.mem[8'h80], pm.mem[8'h81], pm.mem[8'h82]} = 24'h000000;
    run(CMD_EDIT, 16'h0000, 16'h0040, 16'h0080, 16'h0060, 8'h03, rl);
    for (int i = 0; i < 3; i++)
      check8("result char", exp[23-8*i -: 8], pm.mem[8'h80+i]);
    for (int i = 0; i < 4; i++)
      check8("mask byte", mask[31-8*i -: 8], pm.mem[8'h60+i]);
    check16("reg1 after edit", r1e, got_r1 ? r1_seen : 16'h0000);
    if (rl == 8'h00)
      check16("cond written", 16'h0000, {15'h0, got_cc});
    else
      check16("cond bits", {12'h0, cc}, {12'h0, cc_seen[CC_GT], cc_seen[CC_LT], cc_seen[CC_EQ], cc_seen[CC_INV]});
  endtask
  initial begin
    {start, slow, cmd, instr, addr1, addr2, src_len, res_len, reg1_in, cond_in} = '0;
    sys_rst = 1'b1;
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    t_convert();
    t_short();
    t_edit(16'h123C, 32'h28000000, 8'h03, 24'hF1F2F3, 4'h8, 16'h007F);
    t_edit(16'h052D, 32'h29000000, 8'h03, 24'h40F5F2, 4'h4, 16'h0080);
    t_edit(16'h000C, 32'h065C2900, 8'h03, 24'h5C5C5C, 4'h2, 16'h0000);
    t_edit(16'hC1C2, 32'h045B1800, 8'h00, 24'h5BC1C2, 4'h0, 16'h0000);
    summarize();
  end
endmodule
